// ---- inc/pwm_event_consts.svh ----
// Constants for the standby and fault event manager: timing figures and derived counts.
// Assumes the clock runs at the rate given by the clock constants below.
`ifndef PWM_EVENT_CONSTS_SVH
`define PWM_EVENT_CONSTS_SVH

// ==========================================================
// Clock.
`define CLK_FREQ_HZ        50000000
`define CLK_PERIOD_NS      20

// ==========================================================
// Timing figures and cycle counts.
// Leading edge mask time in ns, rounded up to whole cycles.
`define MASK_TIME_NS       250
`define MASK_CYCLES        ((`MASK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Fault and light-load confirmation time in ms.
`define CONFIRM_TIME_MS    125
// Prescaler produces a 1 ms tick.
`define MS_CYCLES          (`CLK_FREQ_HZ / 1000)
// Soft-start time in ms, rounded up.
`define SOFT_START_MS      3
`define SOFT_START_US      2500

`endif

// ---- inc/pwm_event_pkg.sv ----
// Types shared by the standby and fault event manager.
// Assumes the constants header is included by the modules that need numbers.
package pwm_event_pkg;

    // ==========================================================
    // Main operating modes.
    typedef enum logic [2:0] {
        MODE_SOFT_START,
        MODE_NORMAL,
        MODE_FAULT_STOP,
        MODE_LATCH_OFF,
        MODE_RESTART_WAIT,
        MODE_CS_LATCHED
    } mode_t;

    // Synchronised detector levels.
    typedef struct packed {
        logic below_skip;       // Feedback below the lower skip level.
        logic above_skip_hyst;  // Feedback above skip level plus hysteresis.
        logic above_exit;       // Feedback above the standby exit level.
        logic pwm_trip;         // Current sense reached the feedback level.
        logic clamp_hit;        // Current sense reached the fixed clamp.
        logic cs_latch;         // Current sense above the latch level.
        logic uv_low;           // Supply below the low undervoltage threshold.
        logic uv_high;          // Supply above the high undervoltage threshold.
        logic latch_level;      // Supply at or below the latch-off level.
        logic reset_level;      // Supply below the reset level.
    } sense_t;

endpackage : pwm_event_pkg

// ---- hw/level_sync.sv ----
// Two-flop synchroniser for a bundle of detector levels.
// Assumes inputs are slow levels; the first stage feeds only the second.
`timescale 1ns/100ps
module level_sync #(
    parameter int WIDTH = 10
) (
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    input  wire logic [WIDTH-1:0] level_in,
    output logic      [WIDTH-1:0] level_out
);

    // ==========================================================
    // State.
    typedef struct packed {
        logic [WIDTH-1:0] meta;   // First stage, read only by the second.
        logic [WIDTH-1:0] sync;   // Second stage.
    } sync_state_t;

    sync_state_t state_q;          // Registered state.
    sync_state_t state_d;          // Next state.

    // Shift the levels through two stages.
    always_comb begin
        state_d      = state_q;
        state_d.meta = level_in;
        state_d.sync = state_q.meta;
    end

    // Register the stages; reset clears both.
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign level_out = state_q.sync;

endmodule : level_sync

// ---- hw/ms_timer.sv ----
// Millisecond confirmation timer with a clock prescaler.
// Assumes run_in is a level; dropping it clears the count at once.
`timescale 1ns/100ps
`include "pwm_event_consts.svh"
module ms_timer #(
    parameter int TICK_CYCLES = `MS_CYCLES,
    parameter int LIMIT_MS    = `CONFIRM_TIME_MS
) (
    input  wire logic clk_in,
    input  wire logic reset_in,
    input  wire logic run_in,
    output logic      done_out
);

    // ==========================================================
    // State.
    typedef struct packed {
        logic [25:0] pre;     // Prescaler count within one ms.
        logic [15:0] ms;      // Whole ms elapsed.
        logic        done;    // Limit reached.
    } timer_state_t;

    timer_state_t state_q;     // Registered state.
    timer_state_t state_d;     // Next state.

    // Count while running; clear as soon as the run level drops.
    always_comb begin
        state_d = state_q;
        if (!run_in) begin
            state_d = '0;
        end else if (!state_q.done) begin
            if (state_q.pre == 26'(TICK_CYCLES - 1)) begin
                state_d.pre = '0;
                state_d.ms  = state_q.ms + 16'h0001;
                if (state_q.ms == 16'(LIMIT_MS - 1)) begin
                    state_d.done = 1'b1;
                end
            end else begin
                state_d.pre = state_q.pre + 26'h0000001;
            end
        end
    end

    // Register the counter.
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign done_out = state_q.done;

endmodule : ms_timer

// ---- hw/pwm_standby_fault_manager.sv ----
// Event manager of a current-mode PWM controller: skip cycles, bias switch, faults, restart.
// Assumes analog detectors arrive as digital levels and the oscillator pulse lasts one cycle.
// How it works
// - Feedback under quarter peak: clamp, skip pulses.
// - Light load confirmed by timer opens bias switch.
// - Skip bursts follow the hysteretic skip comparator.
// - Bias off in confirmed skip until exit level.
// - Exit level closes bias switch immediately.
// - Clamp level raises the error flag.
// - Mask current sense at on-time start.
// - Error flag held past timer stops drive.
// - Error flag drop resets timer, no action.
// - Confirmed fault enters latch-off at low supply.
// - Startup source on from latch level to high.
// - Restart every second startup sequence, but on the first one after sense latch release.
// - Restart resumes switching when error flag low.
// - Timeout in skip keeps bias switch open.
// - Supply undervoltage enters latch-off directly.
// - Off-time sense over latch level latches off.
// - Sense latch also opens bias switch.
// - Oscillator sets pulse latch, comparator resets.
// - Soft-start reruns on power-up and restart.
`timescale 1ns/100ps
`include "pwm_event_consts.svh"
module pwm_standby_fault_manager
    import pwm_event_pkg::*;
#(
    parameter int MASK_CYC   = `MASK_CYCLES,
    parameter int TICK_CYC   = `MS_CYCLES,
    parameter int CONFIRM_MS = `CONFIRM_TIME_MS,
    parameter int SOFT_MS    = `SOFT_START_MS
) (
    input  wire logic clk_in,
    input  wire logic reset_in,
    input  wire logic osc_pulse_in,          // One-cycle start of each oscillator period.
    input  wire logic fb_below_skip_in,      // Feedback under the skip level.
    input  wire logic fb_above_hyst_in,      // Feedback above skip level plus hysteresis.
    input  wire logic fb_above_exit_in,      // Feedback above the standby exit level.
    input  wire logic pwm_trip_in,           // PWM comparator tripped.
    input  wire logic clamp_hit_in,          // Current sense at the fixed clamp.
    input  wire logic cs_latch_in,           // Current sense above the latch level.
    input  wire logic uv_low_in,             // Supply below the low undervoltage threshold.
    input  wire logic uv_high_in,            // Supply above the high undervoltage threshold.
    input  wire logic latch_level_in,        // Supply at or below the latch-off level.
    input  wire logic reset_level_in,        // Supply below the reset level.
    output logic      drive_out,             // Gate drive request.
    output logic      pfc_supply_switch_out, // Bias switch closed when high.
    output logic      peak_clamp_out,        // Peak current held at the skip floor.
    output logic      skip_mode_out,         // Skip-cycle operation active.
    output logic      soft_start_out,        // Soft-start ramp running.
    output logic      startup_source_out,    // Startup current source on.
    output logic      low_power_out,         // Reduced consumption in latch-off.
    output logic      error_flag_out,        // Maximum-current condition seen.
    output logic      fault_out,             // Fault confirmed.
    output logic      cs_latched_out         // Permanent sense latch set.
);

    // ==========================================================
    // Synchronised inputs.
    sense_t raw_w;                            // Detector levels as they arrive.
    sense_t sense;                            // Detector levels after two flops.
    logic   light_done;                       // Light-load confirmation expired.
    logic   fault_done;                       // Fault confirmation expired.
    logic   soft_done;                        // Soft-start period expired.

    assign raw_w = '{below_skip: fb_below_skip_in, above_skip_hyst: fb_above_hyst_in,
                     above_exit: fb_above_exit_in, pwm_trip: pwm_trip_in,
                     clamp_hit: clamp_hit_in, cs_latch: cs_latch_in, uv_low: uv_low_in,
                     uv_high: uv_high_in, latch_level: latch_level_in,
                     reset_level: reset_level_in};

    // Every detector level crosses through the two-flop stage first.
    level_sync #(
        .WIDTH ($bits(sense_t))
    ) u_sync (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .level_in  (raw_w),
        .level_out (sense)
    );

    // ==========================================================
    // State.
    typedef struct packed {
        mode_t      mode;        // Operating mode.
        logic       pulse;       // Pulse latch.
        logic [7:0] mask_cnt;    // Leading edge mask countdown.
        logic       skip;        // Skip-cycle operation.
        logic       burst_off;   // Bursts suppressed inside skip.
        logic       light_conf;  // Light load confirmed.
        logic       skip_fault;  // Timer expired during skip.
        logic       pfc_on;      // Bias switch closed.
        logic       divider;     // Divide-by-two startup counter.
        logic       src_on;      // Startup current source on.
        logic       error;       // Error flag.
        logic       fault;       // Fault confirmed.
        logic       soft_flag;   // Soft-start output, registered.
        logic       low_flag;    // Latch-off output, registered.
        logic       cs_flag;     // Sense latch output, registered.
    } state_t;

    state_t state_q;              // Registered state.
    state_t state_d;              // Next state.
    logic   on_pulse;             // Pulse latch may be set this period.
    logic   run_light;            // Light-load timer run level.
    logic   run_fault;            // Fault timer run level.
    logic   run_soft;             // Soft-start timer run level.

    // The confirmation timers only count while their condition stays true.
    assign run_light = state_q.skip && sense.below_skip && !state_q.light_conf;
    assign run_fault = state_q.error && (state_q.mode == MODE_NORMAL
                       || state_q.mode == MODE_SOFT_START);
    assign run_soft  = (state_q.mode == MODE_SOFT_START);

    ms_timer #(
        .TICK_CYCLES (TICK_CYC),
        .LIMIT_MS    (CONFIRM_MS)
    ) u_light (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .run_in   (run_light),
        .done_out (light_done)
    );

    ms_timer #(
        .TICK_CYCLES (TICK_CYC),
        .LIMIT_MS    (CONFIRM_MS)
    ) u_fault (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .run_in   (run_fault),
        .done_out (fault_done)
    );

    ms_timer #(
        .TICK_CYCLES (TICK_CYC),
        .LIMIT_MS    (SOFT_MS)
    ) u_soft (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .run_in   (run_soft),
        .done_out (soft_done)
    );

    // ==========================================================
    // Next-state logic. Supply events take priority over feedback events,
    // and the sense latch overrides everything until the supply collapses.
    always_comb begin
        state_d  = state_q;
        on_pulse = (state_q.mode == MODE_NORMAL || state_q.mode == MODE_SOFT_START)
                   && !(state_q.skip && state_q.burst_off);
        // Pulse latch: set by the oscillator, reset by the comparator outside the mask.
        if (state_q.mask_cnt != 8'h00) begin
            state_d.mask_cnt = state_q.mask_cnt - 8'h01;
        end
        if (osc_pulse_in && on_pulse) begin
            state_d.pulse    = 1'b1;
            state_d.mask_cnt = 8'(MASK_CYC);
        end else if (state_q.pulse && state_q.mask_cnt == 8'h00
                     && (sense.pwm_trip || sense.clamp_hit)) begin
            state_d.pulse = 1'b0;
        end
        if (!on_pulse) begin
            state_d.pulse = 1'b0;
        end
        // Error flag follows the clamp, sampled only after the mask.
        if (state_q.pulse && state_q.mask_cnt == 8'h00) begin
            state_d.error = sense.clamp_hit;
        end else if (!state_q.pulse && !sense.clamp_hit) begin
            state_d.error = 1'b0;
        end
        // Skip entry, bursts and exit.
        if (state_q.mode == MODE_NORMAL) begin
            if (!state_q.skip && sense.below_skip) begin
                state_d.skip      = 1'b1;
                state_d.burst_off = 1'b1;
            end else if (state_q.skip && sense.above_exit) begin
                state_d.skip       = 1'b0;
                state_d.burst_off  = 1'b0;
                state_d.light_conf = 1'b0;
                if (!state_q.skip_fault) begin
                    state_d.pfc_on = 1'b1;
                end
            end else if (state_q.skip) begin
                if (sense.below_skip) begin
                    state_d.burst_off = 1'b1;
                end else if (sense.above_skip_hyst) begin
                    state_d.burst_off = 1'b0;
                end
                if (light_done) begin
                    state_d.light_conf = 1'b1;
                    state_d.pfc_on     = 1'b0;
                end
            end
        end
        // Fault confirmation.
        if (fault_done) begin
            state_d.fault = 1'b1;
            state_d.mode  = MODE_FAULT_STOP;
            state_d.pulse = 1'b0;
            if (state_q.skip) begin
                state_d.skip_fault = 1'b1;
                state_d.pfc_on     = 1'b0;
            end
        end
        // Mode sequencing.
        case (state_q.mode)
            MODE_SOFT_START: begin
                if (soft_done && !fault_done) begin
                    state_d.mode = MODE_NORMAL;
                    if (!state_q.error && !state_q.skip_fault) begin
                        state_d.pfc_on = 1'b1;
                    end
                end
            end
            MODE_NORMAL: begin
                if (!state_q.error && !state_q.skip && !state_q.skip_fault) begin
                    state_d.pfc_on = state_q.pfc_on | state_q.fault;
                end
                if (state_q.fault && !state_q.error) begin
                    state_d.fault      = 1'b0;
                    state_d.skip_fault = 1'b0;
                    state_d.pfc_on     = 1'b1;
                end
            end
            MODE_FAULT_STOP: begin
                if (sense.uv_low) begin
                    state_d.mode = MODE_LATCH_OFF;
                end
            end
            MODE_LATCH_OFF: begin
                if (sense.latch_level) begin
                    state_d.src_on = 1'b1;
                    state_d.mode   = MODE_RESTART_WAIT;
                end
            end
            MODE_RESTART_WAIT: begin
                if (sense.uv_high) begin
                    state_d.src_on  = 1'b0;
                    state_d.divider = ~state_q.divider;
                    if (state_q.divider) begin
                        state_d.mode  = MODE_SOFT_START;
                        state_d.error = 1'b0;
                        state_d.skip  = 1'b0;
                        state_d.light_conf = 1'b0;
                    end else begin
                        state_d.mode = MODE_LATCH_OFF;
                    end
                end
            end
            MODE_CS_LATCHED: begin
                state_d.pfc_on = 1'b0;
                // A collapsed supply releases the latch into a fresh startup; the next
                // high threshold restarts at once, as a power-up would.
                if (sense.reset_level && !sense.cs_latch) begin
                    state_d.mode    = MODE_RESTART_WAIT;
                    state_d.src_on  = 1'b1;
                    state_d.divider = 1'b1;
                end
            end
            default: begin
                state_d.mode = MODE_FAULT_STOP;
            end
        endcase
        // Supply undervoltage goes straight to latch-off while running.
        if (sense.uv_low && (state_q.mode == MODE_NORMAL || state_q.mode == MODE_SOFT_START)) begin
            state_d.mode   = MODE_LATCH_OFF;
            state_d.pulse  = 1'b0;
            state_d.skip   = 1'b1;
            state_d.pfc_on = 1'b0;
        end
        // Off-time sense latch is permanent until the supply resets.
        if (sense.cs_latch && !state_q.pulse && state_q.mode != MODE_CS_LATCHED) begin
            state_d.mode   = MODE_CS_LATCHED;
            state_d.pulse  = 1'b0;
            state_d.pfc_on = 1'b0;
            state_d.src_on = 1'b0;
        end
        // Mode decodes are registered so that every output leaves a flip-flop.
        state_d.soft_flag = (state_d.mode == MODE_SOFT_START);
        state_d.low_flag  = (state_d.mode == MODE_LATCH_OFF);
        state_d.cs_flag   = (state_d.mode == MODE_CS_LATCHED);
    end

    // Register all state; a low supply reset reruns soft-start from scratch.
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_q           <= '0;
            state_q.mode      <= MODE_SOFT_START;
            state_q.soft_flag <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Outputs, straight from flip-flops.
    assign drive_out             = state_q.pulse;
    assign pfc_supply_switch_out = state_q.pfc_on;
    assign peak_clamp_out        = state_q.skip;
    assign skip_mode_out         = state_q.skip;
    assign soft_start_out        = state_q.soft_flag;
    assign startup_source_out    = state_q.src_on;
    assign low_power_out         = state_q.low_flag;
    assign error_flag_out        = state_q.error;
    assign fault_out             = state_q.fault;
    assign cs_latched_out        = state_q.cs_flag;

    // ==========================================================
    // Checks.
    sequence seq_osc_set;
        osc_pulse_in && on_pulse && !(sense.cs_latch && !state_q.pulse) && !fault_done
            && !(sense.uv_low && state_q.mode inside {MODE_NORMAL, MODE_SOFT_START});
    endsequence

    AST_PULSE_SET: assert property (@(posedge clk_in) disable iff (reset_in)
        seq_osc_set |=> drive_out) else $error("Oscillator pulse did not set drive.");
    AST_MASK_HOLD: assert property (@(posedge clk_in) disable iff (reset_in)
        (state_q.mask_cnt != 8'h00 && drive_out && on_pulse && !sense.cs_latch
         && !fault_done && !sense.uv_low) |=> drive_out)
        else $error("Drive ended inside the mask.");
    AST_CS_LATCH: assert property (@(posedge clk_in) disable iff (reset_in)
        (sense.cs_latch && !state_q.pulse) |=> (cs_latched_out && !drive_out))
        else $error("Sense latch not taken.");
    AST_CS_PFC: assert property (@(posedge clk_in) disable iff (reset_in)
        cs_latched_out |-> !pfc_supply_switch_out) else $error("Bias switch closed while latched.");
    AST_CS_STAY: assert property (@(posedge clk_in) disable iff (reset_in)
        (cs_latched_out && !sense.reset_level) |=> cs_latched_out) else $error("Sense latch released.");
    AST_CS_RELEASE: assert property (@(posedge clk_in) disable iff (reset_in)
        (cs_latched_out && sense.reset_level && !sense.cs_latch) |=> (!cs_latched_out && startup_source_out))
        else $error("Sense latch not released by supply collapse.");
    AST_NO_DRIVE_FAULT: assert property (@(posedge clk_in) disable iff (reset_in)
        fault_done |=> (!drive_out && fault_out)) else $error("Drive not stopped on fault.");
    AST_UV_DIRECT: assert property (@(posedge clk_in) disable iff (reset_in)
        (sense.uv_low && state_q.mode == MODE_NORMAL && !sense.cs_latch) |=> (low_power_out && skip_mode_out))
        else $error("Undervoltage did not enter latch-off.");
    AST_SRC_ON: assert property (@(posedge clk_in) disable iff (reset_in)
        (state_q.mode == MODE_LATCH_OFF && sense.latch_level && !sense.cs_latch) |=> startup_source_out)
        else $error("Startup source not turned on.");
    AST_DIV_TWO: assert property (@(posedge clk_in) disable iff (reset_in)
        (state_q.mode == MODE_RESTART_WAIT && sense.uv_high && !state_q.divider && !sense.cs_latch)
        |=> low_power_out) else $error("Restart taken on first startup.");
    AST_SKIP_PFC: assert property (@(posedge clk_in) disable iff (reset_in)
        (state_q.light_conf && state_q.skip) |-> !pfc_supply_switch_out)
        else $error("Bias switch closed in confirmed skip.");

endmodule : pwm_standby_fault_manager

// ---- verif/power_stage_model.sv ----
// Model of the power stage: sense comparator levels answering the gate drive.
// Assumes drive_in is the gate request of the manager under test.
`timescale 1ns/100ps
module power_stage_model (
    input  wire logic       clk_in,
    input  wire logic       drive_in,
    input  wire logic       overload_in,
    input  wire logic [7:0] trip_dly_in,
    output logic            pwm_trip_out,
    output logic            clamp_hit_out
);
    logic [7:0] on_q = 8'h00; // Cycles the switch has been on.
    // Current ramps only while on, so the trip follows the on-time.
    always @(negedge clk_in) begin
        on_q <= drive_in ? on_q + 8'h01 : 8'h00;
        pwm_trip_out <= drive_in && (on_q >= trip_dly_in);
        clamp_hit_out <= overload_in;
    end
endmodule : power_stage_model

// ---- verif/test_pwm_standby_fault_manager.sv ----
// Bench for the standby and fault event manager.
// Assumes short timer parameters: one ms is four cycles.
`timescale 1ns/100ps
module test_pwm_standby_fault_manager;
    logic clk_in = 1'b0, reset_in = 1'b1, osc_pulse_in = 1'b0, fb_below_skip_in = 1'b0, fb_above_exit_in = 1'b0;
    logic cs_latch_in = 1'b0, uv_low_in = 1'b0, uv_high_in = 1'b0, latch_level_in = 1'b0, reset_level_in = 1'b0;
    logic fb_above_hyst_in, pwm_trip_in, clamp_hit_in, drive_out, pfc_supply_switch_out, peak_clamp_out;
    logic skip_mode_out, soft_start_out, startup_source_out, low_power_out, error_flag_out, fault_out, cs_latched_out;
    logic overload = 1'b0;
    logic [7:0] trip_dly = 8'h03;
    int failures = 0;
    int checks_done = 0;
    assign fb_above_hyst_in = ~fb_below_skip_in;
    initial forever #10 clk_in = ~clk_in;
    power_stage_model power_stage_model_inst (.clk_in(clk_in), .drive_in(drive_out), .overload_in(overload),
        .trip_dly_in(trip_dly), .pwm_trip_out(pwm_trip_in), .clamp_hit_out(clamp_hit_in));
    pwm_standby_fault_manager #(.TICK_CYC(4), .CONFIRM_MS(3), .SOFT_MS(1)) pwm_standby_fault_manager_inst (
        .clk_in(clk_in), .reset_in(reset_in), .osc_pulse_in(osc_pulse_in), .fb_below_skip_in(fb_below_skip_in),
        .fb_above_hyst_in(fb_above_hyst_in), .fb_above_exit_in(fb_above_exit_in), .pwm_trip_in(pwm_trip_in),
        .clamp_hit_in(clamp_hit_in), .cs_latch_in(cs_latch_in), .uv_low_in(uv_low_in), .uv_high_in(uv_high_in),
        .latch_level_in(latch_level_in), .reset_level_in(reset_level_in), .drive_out(drive_out),
        .pfc_supply_switch_out(pfc_supply_switch_out), .peak_clamp_out(peak_clamp_out),
        .skip_mode_out(skip_mode_out), .soft_start_out(soft_start_out), .startup_source_out(startup_source_out),
        .low_power_out(low_power_out), .error_flag_out(error_flag_out), .fault_out(fault_out),
        .cs_latched_out(cs_latched_out));
    task automatic check(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask : tick
    task automatic pulse(input int n);
        osc_pulse_in = 1'b1;
        tick(1);
        osc_pulse_in = 1'b0;
        tick(n);
    endtask : pulse
    task automatic restart();
        reset_in = 1'b1;
        tick(12);
        check("soft_start", 1'b1, soft_start_out);
        reset_in = 1'b0;
        tick(20);
    endtask : restart
    task automatic test_done();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done
    initial begin
        restart();
        check("switch", 1'b1, pfc_supply_switch_out);
        pulse(4);
        check("drive masked", 1'b1, drive_out);
        tick(20);
        check("drive tripped", 1'b0, drive_out);
        $display("test pulse done");
        fb_below_skip_in = 1'b1;
        tick(6);
        check("skip", 1'b1, skip_mode_out);
        check("peak clamp", 1'b1, peak_clamp_out);
        check("switch held", 1'b1, pfc_supply_switch_out);
        tick(20);
        check("switch open", 1'b0, pfc_supply_switch_out);
        fb_below_skip_in = 1'b0;
        fb_above_exit_in = 1'b1;
        tick(4);
        check("switch back", 1'b1, pfc_supply_switch_out);
        fb_above_exit_in = 1'b0;
        $display("test skip done");
        trip_dly = 8'h20;
        overload = 1'b1;
        // The period must outlast the mask, or each pulse reloads it and the clamp is never seen.
        repeat (3) pulse(19);
        check("fault", 1'b1, fault_out);
        check("error flag", 1'b1, error_flag_out);
        pulse(3);
        check("drive stopped", 1'b0, drive_out);
        uv_low_in = 1'b1;
        tick(4);
        check("low power", 1'b1, low_power_out);
        $display("test fault done");
        overload = 1'b0;
        uv_low_in = 1'b0;
        restart();
        cs_latch_in = 1'b1;
        tick(4);
        check("cs latched", 1'b1, cs_latched_out);
        check("drive off", 1'b0, drive_out);
        check("switch off", 1'b0, pfc_supply_switch_out);
        cs_latch_in = 1'b0;
        reset_level_in = 1'b1;
        tick(4);
        check("cs released", 1'b0, cs_latched_out);
        check("startup source", 1'b1, startup_source_out);
        $display("test latch done");
        test_done();
    end
    // Whole run is about 200 cycles; the watchdog allows far more.
    initial begin
        tick(5000);
        failures++;
        test_done();
    end
endmodule : test_pwm_standby_fault_manager
